// File: rbk_params.svh
`ifndef RBK_PARAMS_SVH
`define RBK_PARAMS_SVH

`define RBK_ARRAY_BITS    9216
`define RBK_ADDR_BITS     13
`define RBK_CS_BITS       3
`define RBK_CS_DEFAULT    3'h0
`define RBK_WIDTH_DEFAULT 1
`define RBK_DEPTH_X1      8192
`define RBK_DEPTH_X2      4096
`define RBK_DEPTH_X4      2048
`define RBK_DEPTH_X9      1024
`define RBK_DEPTH_X18     512
`define RBK_DEPTH_X36     256
`define RBK_PIPE_RESET    1'b0

`endif

// File: rbk_pkg.sv
`include "rbk_params.svh"

package rbk_pkg;

   typedef enum logic {RBK_UNREGISTERED_OUTPUT, RBK_REGISTERED_OUTPUT} rbk_output_pipeline_option_t;
   typedef enum logic {RBK_RESET_ASYNC, RBK_RESET_SYNC} rbk_reset_t;
   typedef enum logic {RBK_SIMPLE_DUAL_PORT_RAM, RBK_ROM} rbk_mode_t;

   // words per block for a port width; unsupported widths give 0
   function automatic int rbk_depth(input int width);
      case (width)
         1:       return `RBK_DEPTH_X1;
         2:       return `RBK_DEPTH_X2;
         4:       return `RBK_DEPTH_X4;
         9:       return `RBK_DEPTH_X9;
         18:      return `RBK_DEPTH_X18;
         36:      return `RBK_DEPTH_X36;
         default: return 0;
      endcase
   endfunction

   // first array bit of a word; address bits above the depth are ignored
   function automatic int rbk_base(input logic [`RBK_ADDR_BITS-1:0] addr, input int width);
      int depth;
      depth = rbk_depth(width);
      if (depth == 0) begin
         return 0;
      end
      return (int'(addr) % depth) * width;
   endfunction

endpackage

// File: rbk_store.sv
`timescale 1ns/1ps
`default_nettype none
`include "rbk_params.svh"

module rbk_store #(
   parameter int                         WRITE_WIDTH = `RBK_WIDTH_DEFAULT,
   parameter int                         READ_WIDTH  = `RBK_WIDTH_DEFAULT,
   parameter logic [`RBK_ARRAY_BITS-1:0] INIT_BITS   = '0
) (
   input  wire logic                      clk,            // system clock
   input  wire logic                      commit,         // write the held word
   input  wire logic [`RBK_ADDR_BITS-1:0] commit_address, // held write address
   input  wire logic [WRITE_WIDTH-1:0]    commit_data,    // held write word
   input  wire logic [`RBK_ADDR_BITS-1:0] read_address,   // held read address
   output logic      [READ_WIDTH-1:0]     read_word       // array output
);
   import rbk_pkg::*;

   // contents have no reset at all, so pipeline resets never disturb them
   logic [`RBK_ARRAY_BITS-1:0] mem = INIT_BITS;
   int                         write_base;
   int                         read_base;

   assign write_base = rbk_base(commit_address, WRITE_WIDTH);
   assign read_base  = rbk_base(read_address, READ_WIDTH);
   assign read_word  = mem[read_base +: READ_WIDTH];

   always_ff @(posedge clk) begin
      if (commit) begin
         mem[write_base +: WRITE_WIDTH] <= commit_data;
      end
   end

endmodule

`default_nettype wire

// File: rbk_block_ram.sv
`timescale 1ns/1ps
`default_nettype none
`include "rbk_params.svh"

module rbk_block_ram #(
   parameter int                      WRITE_WIDTH            = `RBK_WIDTH_DEFAULT,
   parameter int                      READ_WIDTH             = `RBK_WIDTH_DEFAULT,
   parameter rbk_pkg::rbk_mode_t      memory_mode            = rbk_pkg::RBK_SIMPLE_DUAL_PORT_RAM,
   parameter rbk_pkg::rbk_output_pipeline_option_t   output_pipeline_option = rbk_pkg::RBK_UNREGISTERED_OUTPUT,
   parameter rbk_pkg::rbk_reset_t     reset_type_select      = rbk_pkg::RBK_RESET_ASYNC,
   parameter logic [`RBK_CS_BITS-1:0] write_select_match     = `RBK_CS_DEFAULT,
   parameter logic [`RBK_CS_BITS-1:0] read_select_match      = `RBK_CS_DEFAULT,
   parameter logic [`RBK_ARRAY_BITS-1:0] INIT_BITS           = '0
) (
   input  wire logic                      clk,                // system clock
   input  wire logic                      resetn,             // system reset, low
   input  wire logic                      pipe_reset,         // pipeline reset, high
   input  wire logic                      write_clock_enable, // write port enable
   input  wire logic                      write_enable,       // write request
   input  wire logic [`RBK_CS_BITS-1:0]   write_chip_select,  // write block select
   input  wire logic [`RBK_ADDR_BITS-1:0] write_address,      // write word address
   input  wire logic [WRITE_WIDTH-1:0]    write_data,         // write word
   input  wire logic                      read_clock_enable,  // read port enable
   input  wire logic [`RBK_CS_BITS-1:0]   read_chip_select,   // read block select
   input  wire logic [`RBK_ADDR_BITS-1:0] read_address,       // read word address
   output logic      [READ_WIDTH-1:0]     read_data           // read word
);
   import rbk_pkg::*;

   localparam int PIPE_BITS = 1 + 2 * `RBK_ADDR_BITS + WRITE_WIDTH + READ_WIDTH;

   // a port answers only when its select lines carry its own match value
   function automatic logic select_hit(input logic [`RBK_CS_BITS-1:0] cs,
                                       input logic [`RBK_CS_BITS-1:0] match);
      return cs == match;
   endfunction

   logic                      rst;
   logic                      write_selected;
   logic                      read_selected;
   logic                      write_fire;
   logic                      read_fire;
   logic                      write_hold;
   logic                      we_q;
   logic [`RBK_ADDR_BITS-1:0] wa_q;
   logic [WRITE_WIDTH-1:0]    wd_q;
   logic [`RBK_ADDR_BITS-1:0] ra_q;
   logic [READ_WIDTH-1:0]     out_q;
   logic                      next_we;
   logic [`RBK_ADDR_BITS-1:0] next_wa;
   logic [WRITE_WIDTH-1:0]    next_wd;
   logic [`RBK_ADDR_BITS-1:0] next_ra;
   logic [READ_WIDTH-1:0]     next_out;
   logic [READ_WIDTH-1:0]     array_word;
   logic [PIPE_BITS-1:0]      pipe_q;
   logic [PIPE_BITS-1:0]      next_pipe;

   // either reset source clears the pipeline
   assign rst = pipe_reset | ~resetn;

   // select bits are the block's top address bits; deeper cascades need outside decode
   assign write_selected = select_hit(write_chip_select, write_select_match);
   assign read_selected  = select_hit(read_chip_select, read_select_match);

   // a rom never commits a write; its write address and data are still registered
   assign write_hold = (memory_mode == RBK_ROM);
   assign write_fire = write_clock_enable & write_enable & write_selected & ~write_hold;
   assign read_fire  = read_clock_enable & read_selected;

   // write address and data load on write_clock_enable, read address on read_fire; we_q reloads every edge
   assign next_we  = write_fire;
   assign next_wa  = write_clock_enable ? write_address : wa_q;
   assign next_wd  = write_clock_enable ? write_data : wd_q;
   assign next_ra  = read_fire ? read_address : ra_q;
   assign next_out = read_fire ? array_word : out_q;

   assign next_pipe = {next_we, next_wa, next_wd, next_ra, next_out};
   assign {we_q, wa_q, wd_q, ra_q, out_q} = pipe_q;

   // reset flavour picked at build time; both clear only the pipeline
   generate
      if (reset_type_select == RBK_RESET_ASYNC) begin : g_async
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               pipe_q <= '0;
            end else begin
               pipe_q <= next_pipe;
            end
         end
      end else begin : g_sync
         always_ff @(posedge clk) begin
            if (rst) begin
               pipe_q <= '0;
            end else begin
               pipe_q <= next_pipe;
            end
         end
      end
   endgenerate

   // one 9,216-bit array shared by all shapes, preloaded for rom use
   rbk_store #(
      .WRITE_WIDTH (WRITE_WIDTH),
      .READ_WIDTH  (READ_WIDTH),
      .INIT_BITS   (INIT_BITS)
   ) u_store (
      .clk            (clk),
      .commit         (we_q),
      .commit_address (wa_q),
      .commit_data    (wd_q),
      .read_address   (ra_q),
      .read_word      (array_word)
   );

   // unregistered mode trades clock rate for one cycle less latency
   assign read_data = (output_pipeline_option == RBK_REGISTERED_OUTPUT) ?
                      out_q : array_word;

   AST_WRITE_CAPTURE: assert property (
      @(posedge clk) disable iff (rst)
      write_clock_enable |=> (wa_q == $past(write_address)) && (wd_q == $past(write_data)))
      else $error("write inputs not captured");

   AST_READ_CAPTURE: assert property (
      @(posedge clk) disable iff (rst)
      read_fire |=> ra_q == $past(read_address))
      else $error("read address not captured");

   AST_READ_HOLD: assert property (
      @(posedge clk) disable iff (rst)
      !read_fire |=> $stable(ra_q) && $stable(out_q))
      else $error("read path moved without read enable");

   AST_WRITE_GATE: assert property (
      @(posedge clk) disable iff (rst)
      we_q |-> $past(write_clock_enable) && $past(write_enable))
      else $error("write committed without enable pair");

   AST_WRITE_SELECT: assert property (
      @(posedge clk) disable iff (rst)
      (write_chip_select != write_select_match) |=> !we_q)
      else $error("write accepted with wrong chip select");

   AST_READ_SELECT: assert property (
      @(posedge clk) disable iff (rst)
      (read_clock_enable && (read_chip_select != read_select_match)) |=> $stable(ra_q))
      else $error("read accepted with wrong chip select");

   AST_ROM_NO_WRITE: assert property (
      @(posedge clk) disable iff (rst)
      (memory_mode == RBK_ROM) |-> !we_q)
      else $error("write path active in rom mode");

   AST_PIPE_RESET: assert property (
      @(posedge clk)
      rst |=> (ra_q == '0) && !we_q && (out_q == '0))
      else $error("pipeline registers not cleared by reset");

   AST_LATENCY: assert property (
      @(posedge clk) disable iff (rst)
      read_fire ##1 read_fire |=>
         read_data == ((output_pipeline_option == RBK_REGISTERED_OUTPUT) ?
                       $past(array_word) :
                       u_store.mem[rbk_base($past(read_address), READ_WIDTH) +: READ_WIDTH]))
      else $error("read latency wrong for output option");

   AST_SHAPE_FITS: assert property (
      @(posedge clk) disable iff (rst)
      (rbk_base(ra_q, READ_WIDTH) + READ_WIDTH <= `RBK_ARRAY_BITS) &&
      (rbk_base(wa_q, WRITE_WIDTH) + WRITE_WIDTH <= `RBK_ARRAY_BITS))
      else $error("word falls outside the array");

   AST_WRITE_QUEUE: assert property (
      @(posedge clk) disable iff (rst)
      write_fire |=> we_q)
      else $error("enabled write not queued");

   AST_WRITE_IDLE: assert property (
      @(posedge clk) disable iff (rst)
      !write_clock_enable |=> !we_q && $stable(wa_q) && $stable(wd_q))
      else $error("write inputs moved without write clock enable");

   AST_WRITE_LANDS: assert property (
      @(posedge clk) disable iff (rst)
      we_q |=> u_store.mem[rbk_base($past(wa_q), WRITE_WIDTH) +: WRITE_WIDTH] == $past(wd_q))
      else $error("queued write did not reach the array");

   AST_OUT_CAPTURE: assert property (
      @(posedge clk) disable iff (rst)
      read_fire |=> out_q == $past(array_word))
      else $error("output register missed the array word");

   AST_OUT_STEADY: assert property (
      @(posedge clk) disable iff (rst)
      (output_pipeline_option == RBK_REGISTERED_OUTPUT) && !read_fire |=> $stable(read_data))
      else $error("registered read data moved without read enable");

   AST_READ_SELECT_OUT: assert property (
      @(posedge clk) disable iff (rst)
      (read_clock_enable && !select_hit(read_chip_select, read_select_match))
         |=> $stable(out_q))
      else $error("output register loaded with wrong chip select");

   AST_ARRAY_KEPT: assert property (
      @(posedge clk)
      rst && !we_q |=> $stable(u_store.mem))
      else $error("array contents disturbed by reset");

endmodule

`default_nettype wire

// File: rbk_fabric.sv
`timescale 1ns/1ps
`default_nettype none

module rbk_fabric (
   input  wire logic        clk,                // system clock
   output logic             write_clock_enable, // write port enable
   output logic             write_enable,       // write request
   output logic [2:0]       write_chip_select,  // write block select
   output logic [12:0]      write_address,      // write word address
   output logic [8:0]       write_data,         // write word
   output logic             read_clock_enable,  // read port enable
   output logic [2:0]       read_chip_select,   // read block select
   output logic [12:0]      read_address        // read word address
);
   initial begin
      {write_clock_enable, write_enable, read_clock_enable} = 3'h0;
      {write_chip_select, read_chip_select} = 6'h00;
      {write_address, read_address} = 26'h0000000;
      write_data = 9'h000;
   end

   // callers enter and leave one step after a rising edge
   task automatic wr(input logic ce, input logic we, input logic [2:0] cs,
                     input logic [12:0] a, input logic [8:0] d);
      write_clock_enable = ce;
      write_enable = we;
      write_chip_select = cs;
      write_address = a;
      write_data = d;
      @(posedge clk);
      #1;
      write_clock_enable = 1'b0;
      write_enable = 1'b0;
      // released lines show junk, not the last value
      write_address = ~a;
      write_data = ~d;
      // idle edge so a following call never re-raises the enables in this step
      @(posedge clk);
      #1;
   endtask

   task automatic rd_start(input logic [2:0] cs, input logic [12:0] a);
      read_clock_enable = 1'b1;
      read_chip_select = cs;
      read_address = a;
      @(posedge clk);
      #1;
   endtask

   task automatic rd_end;
      @(posedge clk);
      #1;
      read_clock_enable = 1'b0;
      read_address = ~read_address;
      @(posedge clk);
      #1;
   endtask
endmodule

`default_nettype wire

// File: block_ram_dual_port_rom_bench.sv
`timescale 1ns/1ps
`default_nettype none

module block_ram_dual_port_rom_bench;
   import rbk_pkg::*;
   localparam logic [9215:0] INIT = 9216'h1A5;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        pipe_reset = 1'b0;
   wire logic   write_clock_enable, write_enable, read_clock_enable;
   wire logic [2:0]  write_chip_select, read_chip_select;
   wire logic [12:0] write_address, read_address;
   wire logic [8:0]  write_data, q_un, q_reg, q_rom;
   int          miscompares = 0;
   int          tests_run = 0;

   always #2.5 clk = ~clk;

   rbk_fabric fab (.clk, .write_clock_enable, .write_enable, .write_chip_select,
      .write_address, .write_data, .read_clock_enable, .read_chip_select, .read_address);
   rbk_block_ram #(.WRITE_WIDTH(9), .READ_WIDTH(9), .INIT_BITS(INIT)) uut (.clk, .resetn,
      .pipe_reset, .write_clock_enable, .write_enable, .write_chip_select, .write_address,
      .write_data, .read_clock_enable, .read_chip_select, .read_address, .read_data(q_un));
   rbk_block_ram #(.WRITE_WIDTH(9), .READ_WIDTH(9), .INIT_BITS(INIT),
      .output_pipeline_option(RBK_REGISTERED_OUTPUT), .reset_type_select(RBK_RESET_SYNC))
      uut_piped (.clk, .resetn, .pipe_reset, .write_clock_enable, .write_enable,
      .write_chip_select, .write_address, .write_data, .read_clock_enable,
      .read_chip_select, .read_address, .read_data(q_reg));
   rbk_block_ram #(.WRITE_WIDTH(9), .READ_WIDTH(9), .INIT_BITS(INIT), .memory_mode(RBK_ROM))
      uut_rom (.clk, .resetn, .pipe_reset, .write_clock_enable, .write_enable,
      .write_chip_select, .write_address, .write_data, .read_clock_enable,
      .read_chip_select, .read_address, .read_data(q_rom));

   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic test_done;
      $display("checks run %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic t_write_read;
      fab.rd_start(3'h0, 13'h0000);
      check(q_un, 9'h1A5);
      check(q_rom, 9'h1A5);
      fab.rd_end();
      check(q_reg, 9'h1A5);
      fab.wr(1'b1, 1'b1, 3'h0, 13'h0005, 9'h0C3);
      fab.wr(1'b1, 1'b1, 3'h0, 13'h0006, 9'h13C);
      fab.rd_start(3'h0, 13'h0005);
      check(q_un, 9'h0C3);
      check(q_reg, 9'h1A5);
      check(q_rom, 9'h000);
      fab.rd_end();
      check(q_reg, 9'h0C3);
      fab.rd_start(3'h0, 13'h0006);
      fab.rd_end();
      check(q_un, 9'h13C);
   endtask

   task automatic t_refused;
      fab.wr(1'b1, 1'b0, 3'h0, 13'h0005, 9'h0FF);
      fab.wr(1'b0, 1'b1, 3'h0, 13'h0005, 9'h0FE);
      fab.wr(1'b1, 1'b1, 3'h1, 13'h0005, 9'h0FD);
      fab.rd_start(3'h1, 13'h0005);
      fab.rd_end();
      check(q_un, 9'h13C);
      fab.rd_start(3'h0, 13'h0005);
      fab.rd_end();
      check(q_reg, 9'h0C3);
      check(q_un, 9'h0C3);
   endtask

   task automatic t_wrap;
      // 1K x 9 shape: address 0x405 aliases word 5
      fab.wr(1'b1, 1'b1, 3'h0, 13'h0405, 9'h055);
      fab.rd_start(3'h0, 13'h0005);
      fab.rd_end();
      check(q_reg, 9'h055);
   endtask

   task automatic t_reset;
      pipe_reset = 1'b1;
      #1;
      check(q_un, 9'h1A5);
      check(q_reg, 9'h055);
      @(posedge clk);
      #1;
      check(q_reg, 9'h000);
      pipe_reset = 1'b0;
      fab.rd_start(3'h0, 13'h0005);
      fab.rd_end();
      check(q_reg, 9'h055);
      check(q_un, 9'h055);
   endtask

   initial begin
      repeat (20) @(posedge clk);
      #1;
      resetn = 1'b1;
      t_write_read();
      t_refused();
      t_wrap();
      t_reset();
      test_done();
   end

   // tests need about 54 cycles with the idle edges
   initial begin
      #5000;
      miscompares++;
      test_done();
   end
endmodule

`default_nettype wire
